//--- src/trpc_perf_counters.sv
// Receive performance counters, data-link capture and signaling pointer with Avalon-MM slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
module trpc_perf_counters
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Receive framer events
    input wire logic rxMultiframeBegin,
    input wire logic oneSecondTick,
    input wire logic crcErrorMf,
    input wire logic framingError,
    input wire logic frameAlignLost,
    input wire logic multiframeAlignLost,
    input wire logic alignChange,
    // Sequence monitor
    input wire logic prbsBitError,
    input wire logic seqSyncFlag,
    input wire logic rxBitStrobe,
    // Data-link bits and signaling updates
    input wire logic dlBitStrobe,
    input wire logic dlBit,
    input wire logic [6:0] dlFrameNum,
    input wire logic [7:0] sigRegUpdated
);

    logic [7:0] ctrl;
    logic [3:0] freeze;
    logic [3:0] freezeDly;
    logic [15:0] cnt [trpc_pkg::NUM_CNT];
    logic [15:0] cntBuf [trpc_pkg::NUM_CNT];
    logic [15:0] next_cnt [trpc_pkg::NUM_CNT];
    logic [3:0] incVec;
    logic ack;
    logic accept;
    logic rdAccept;
    logic wrAccept;
    logic [7:0] readValue;
    logic blockErr;
    logic simDone;
    logic simBitPhase;
    logic [7:0] dlStage [3];
    logic [7:0] rxDatalinkBits1;
    logic [7:0] rxDatalinkBits2;
    logic [7:0] rxDatalinkBits3;
    logic [7:0] rxSignalingChangePtr1;
    logic [5:0] dlSlot;
    logic errNow;
    logic alignMfInc;
    logic alignChgInc;
    logic latchMode;
    logic alarmSim;
    logic isEsf;
    logic [2:0] hiSel;
    trpc_pkg::trpc_format_e fmt;

    function automatic logic [15:0] sat16(input logic [15:0] v);
        return (&v) ? v : v + 16'h0001;
    endfunction

    function automatic logic [7:0] alignStep(input logic [7:0] v, input logic mfInc, input logic chgInc);
        logic [5:0] mf;
        logic [1:0] chg;
        mf = v[7:trpc_pkg::ALIGN_MF_LSB];
        chg = v[trpc_pkg::ALIGN_CHG_MSB:0];
        if (mfInc && !(&mf))
        begin
            mf = mf + 6'h01;
        end
        if (chgInc && !(&chg))
        begin
            chg = chg + 2'h1;
        end
        return {mf, chg};
    endfunction

    // Returns {valid, register, bit} for a data-link bit in the given frame
    function automatic logic [5:0] slotOf(input logic [6:0] frame, input logic [6:0] first,
                                          input logic [6:0] last, input logic [1:0] regSel);
        logic [6:0] off;
        off = frame - first;
        if (frame >= first && frame <= last && !off[0])
        begin
            return {1'b1, regSel, off[3:1]};
        end
        return 6'h00;
    endfunction

    function automatic logic [5:0] dlSlotOf(input trpc_pkg::trpc_format_e f, input logic [6:0] frame);
        logic [5:0] s;
        s = 6'h00;
        unique case (f)
            trpc_pkg::FMT_ESF:
            begin
                s = slotOf(frame, trpc_pkg::DL1_F24_FIRST, trpc_pkg::DL1_F24_LAST, 2'h0)
                  | slotOf(frame, trpc_pkg::DL2_F24_FIRST, trpc_pkg::DL2_F24_LAST, 2'h1);
            end
            trpc_pkg::FMT_F72:
            begin
                s = slotOf(frame, trpc_pkg::DL1_F72_FIRST, trpc_pkg::DL1_F72_LAST, 2'h0)
                  | slotOf(frame, trpc_pkg::DL2_F72_FIRST, trpc_pkg::DL2_F72_LAST, 2'h1)
                  | slotOf(frame, trpc_pkg::DL3_F72_FIRST, trpc_pkg::DL3_F72_LAST, 2'h2);
            end
            trpc_pkg::FMT_F12:
            begin
                s = slotOf(frame, trpc_pkg::DL1_F12_FIRST, trpc_pkg::DL1_F12_LAST, 2'h0);
            end
            trpc_pkg::FMT_F4:
            begin
                s = 6'h00;
            end
        endcase
        return s;
    endfunction

    // Returns {hit, slot} when the address is a counter high byte
    function automatic logic [2:0] hiByteOf(input logic [7:0] a);
        unique case (a)
            trpc_pkg::REG_CRC_HI: return {1'b1, 2'(trpc_pkg::CNT_CRC)};
            trpc_pkg::REG_BLOCK_HI: return {1'b1, 2'(trpc_pkg::CNT_BLOCK)};
            trpc_pkg::REG_BITERR_HI: return {1'b1, 2'(trpc_pkg::CNT_BITERR)};
            trpc_pkg::REG_ALIGN_EVT_HI: return {1'b1, 2'(trpc_pkg::CNT_ALIGN)};
            default: return 3'h0;
        endcase
    endfunction

    assign fmt = trpc_pkg::trpc_format_e'(ctrl[trpc_pkg::CTRL_FMT_MSB:trpc_pkg::CTRL_FMT_LSB]);
    assign latchMode = ctrl[trpc_pkg::CTRL_LATCH_MODE];
    assign alarmSim = ctrl[trpc_pkg::CTRL_ALARM_SIM];
    assign isEsf = (fmt == trpc_pkg::FMT_ESF);
    assign hiSel = hiByteOf(avs_address);

    // Bus handshake: one wait cycle, then accept
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign accept = (avs_read || avs_write) && ack;
    assign rdAccept = accept && avs_read;
    assign wrAccept = accept && avs_write;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= (avs_read || avs_write) && !ack;
            if (avs_read && !ack)
            begin
                avs_readdata <= {24'h00_0000, readValue};
            end
        end
    end

    always_comb
    begin
        unique case (avs_address)
            trpc_pkg::REG_CRC_LO: readValue = cntBuf[trpc_pkg::CNT_CRC][7:0];
            trpc_pkg::REG_CRC_HI: readValue = cntBuf[trpc_pkg::CNT_CRC][15:8];
            trpc_pkg::REG_BLOCK_LO: readValue = cntBuf[trpc_pkg::CNT_BLOCK][7:0];
            trpc_pkg::REG_BLOCK_HI: readValue = cntBuf[trpc_pkg::CNT_BLOCK][15:8];
            trpc_pkg::REG_BITERR_LO: readValue = cntBuf[trpc_pkg::CNT_BITERR][7:0];
            trpc_pkg::REG_BITERR_HI: readValue = cntBuf[trpc_pkg::CNT_BITERR][15:8];
            trpc_pkg::REG_ALIGN_EVT: readValue = cntBuf[trpc_pkg::CNT_ALIGN][7:0];
            trpc_pkg::REG_DL1: readValue = rxDatalinkBits1;
            trpc_pkg::REG_DL2: readValue = rxDatalinkBits2;
            trpc_pkg::REG_DL3: readValue = rxDatalinkBits3;
            trpc_pkg::REG_SIG_PTR1: readValue = rxSignalingChangePtr1;
            trpc_pkg::REG_CTRL: readValue = ctrl;
            trpc_pkg::REG_FREEZE: readValue = {4'h0, freeze};
            trpc_pkg::REG_STATUS: readValue = {5'h00, multiframeAlignLost, frameAlignLost, seqSyncFlag};
            default: readValue = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl <= trpc_pkg::CTRL_RESET;
        end
        else if (wrAccept && avs_address == trpc_pkg::REG_CTRL)
        begin
            ctrl <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            freeze <= 4'h0;
            freezeDly <= 4'h0;
        end
        else
        begin
            freezeDly <= freeze;
            if (wrAccept && avs_address == trpc_pkg::REG_FREEZE)
            begin
                freeze <= avs_writedata[3:0];
            end
            else if (rdAccept && hiSel[2])
            begin
                freeze[hiSel[1:0]] <= 1'b0;
            end
        end
    end

    // Errors seen during the current multiframe, synchronous state only
    assign errNow = !frameAlignLost && (framingError || (isEsf && crcErrorMf));

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            blockErr <= 1'b0;
        end
        else if (rxMultiframeBegin)
        begin
            blockErr <= 1'b0;
        end
        else if (errNow)
        begin
            blockErr <= 1'b1;
        end
    end

    // Simulation state: single block count outside ESF, bit phase for every second bit
    always_ff @(posedge clk)
    begin
        if (rst || !alarmSim)
        begin
            simDone <= 1'b0;
            simBitPhase <= 1'b0;
        end
        else
        begin
            if (rxMultiframeBegin)
            begin
                simDone <= 1'b1;
            end
            if (rxBitStrobe)
            begin
                simBitPhase <= !simBitPhase;
            end
        end
    end

    always_comb
    begin
        incVec = 4'h0;
        incVec[trpc_pkg::CNT_CRC] = isEsf && ctrl[trpc_pkg::CTRL_CRC_EN]
            && ((!frameAlignLost && crcErrorMf) || (alarmSim && rxMultiframeBegin));
        // Errored block counting at multiframe boundary
        incVec[trpc_pkg::CNT_BLOCK] = rxMultiframeBegin
            && ((blockErr || errNow) || (alarmSim && (isEsf || !simDone)));
        incVec[trpc_pkg::CNT_BITERR] = (ctrl[trpc_pkg::CTRL_SEQ_MON_EN] && seqSyncFlag && prbsBitError)
            || (alarmSim && rxBitStrobe && simBitPhase);
        incVec[trpc_pkg::CNT_ALIGN] = 1'b0;
    end

    assign alignMfInc = ctrl[trpc_pkg::CTRL_ALIGN_EVT_EN] && rxMultiframeBegin
        && (frameAlignLost || multiframeAlignLost);
    // Alignment changes, plus one per multiframe in simulation
    assign alignChgInc = (ctrl[trpc_pkg::CTRL_ALIGN_EVT_EN] && alignChange) || (alarmSim && rxMultiframeBegin);

    always_comb
    begin
        for (int i = 0; i < trpc_pkg::NUM_CNT; i++)
        begin
            next_cnt[i] = incVec[i] ? sat16(cnt[i]) : cnt[i];
        end
        next_cnt[trpc_pkg::CNT_ALIGN] = {8'h00, alignStep(cnt[trpc_pkg::CNT_ALIGN][7:0], alignMfInc, alignChgInc)};
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < trpc_pkg::NUM_CNT; i++)
        begin
            if (rst)
            begin
                cnt[i] <= trpc_pkg::CNT_RESET;
                cntBuf[i] <= trpc_pkg::CNT_RESET;
            end
            else if (latchMode)
            begin
                if (oneSecondTick)
                begin
                    cntBuf[i] <= cnt[i];
                    cnt[i] <= trpc_pkg::CNT_RESET;
                end
                else
                begin
                    cnt[i] <= next_cnt[i];
                end
            end
            else
            begin
                // Freeze rise clears counter, buffer held
                if (freeze[i] && !freezeDly[i])
                begin
                    cnt[i] <= trpc_pkg::CNT_RESET;
                end
                else
                begin
                    cnt[i] <= next_cnt[i];
                end
                if (!freeze[i])
                begin
                    cntBuf[i] <= cnt[i];
                end
            end
        end
    end

    assign dlSlot = dlSlotOf(fmt, dlFrameNum);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int r = 0; r < 3; r++)
            begin
                dlStage[r] <= trpc_pkg::DL_RESET;
            end
        end
        else if (dlBitStrobe && dlSlot[5])
        begin
            dlStage[dlSlot[4:3]][dlSlot[2:0]] <= dlBit;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rxDatalinkBits1 <= trpc_pkg::DL_RESET;
            rxDatalinkBits2 <= trpc_pkg::DL_RESET;
            rxDatalinkBits3 <= trpc_pkg::DL_RESET;
        end
        else if (rxMultiframeBegin)
        begin
            rxDatalinkBits1 <= dlStage[0];
            // Second register in F24 and F72 only
            if (isEsf || fmt == trpc_pkg::FMT_F72)
            begin
                rxDatalinkBits2 <= dlStage[1];
            end
            if (fmt == trpc_pkg::FMT_F72)
            begin
                rxDatalinkBits3 <= dlStage[2];
            end
        end
    end

    // Signaling change pointer, read clears only reported bits, set wins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rxSignalingChangePtr1 <= trpc_pkg::SIG_PTR_RESET;
        end
        else if (rdAccept && avs_address == trpc_pkg::REG_SIG_PTR1)
        begin
            rxSignalingChangePtr1 <= (rxSignalingChangePtr1 & ~avs_readdata[7:0]) | sigRegUpdated;
        end
        else
        begin
            rxSignalingChangePtr1 <= rxSignalingChangePtr1 | sigRegUpdated;
        end
    end

endmodule

//--- common/trpc_pkg.sv
// Package of register map, field positions and modes for the receive performance counters
package trpc_pkg;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int NUM_CNT = 4;
    // Register indices; byte address is four times the index
    localparam logic [7:0] REG_CRC_LO = 8'h54;
    localparam logic [7:0] REG_CRC_HI = 8'h55;
    localparam logic [7:0] REG_BLOCK_LO = 8'h56;
    localparam logic [7:0] REG_BLOCK_HI = 8'h57;
    localparam logic [7:0] REG_BITERR_LO = 8'h58;
    localparam logic [7:0] REG_BITERR_HI = 8'h59;
    localparam logic [7:0] REG_ALIGN_EVT = 8'h5a;
    localparam logic [7:0] REG_ALIGN_EVT_HI = 8'h5b;
    localparam logic [7:0] REG_DL1 = 8'h5c;
    localparam logic [7:0] REG_DL2 = 8'h5d;
    localparam logic [7:0] REG_DL3 = 8'h5e;
    localparam logic [7:0] REG_SIG_PTR1 = 8'h62;
    localparam logic [7:0] REG_CTRL = 8'h70;
    localparam logic [7:0] REG_FREEZE = 8'h71;
    localparam logic [7:0] REG_STATUS = 8'h72;
    // Control register fields
    localparam int CTRL_LATCH_MODE = 0;
    localparam int CTRL_SEQ_MON_EN = 1;
    localparam int CTRL_ALIGN_EVT_EN = 2;
    localparam int CTRL_ALARM_SIM = 3;
    localparam int CTRL_CRC_EN = 4;
    localparam int CTRL_FMT_LSB = 5;
    localparam int CTRL_FMT_MSB = 6;
    // Counter slots, also freeze bit positions
    localparam int CNT_CRC = 0;
    localparam int CNT_BLOCK = 1;
    localparam int CNT_BITERR = 2;
    localparam int CNT_ALIGN = 3;
    // Alignment event counter fields
    localparam int ALIGN_MF_LSB = 2;
    localparam int ALIGN_CHG_MSB = 1;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SIG_PTR_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [7:0] DL_RESET = 8'h00;
    // First and last frame of each data-link capture window
    localparam logic [6:0] DL1_F24_FIRST = 7'h01;
    localparam logic [6:0] DL1_F24_LAST = 7'h0f;
    localparam logic [6:0] DL2_F24_FIRST = 7'h11;
    localparam logic [6:0] DL2_F24_LAST = 7'h17;
    localparam logic [6:0] DL1_F72_FIRST = 7'h1a;
    localparam logic [6:0] DL1_F72_LAST = 7'h28;
    localparam logic [6:0] DL2_F72_FIRST = 7'h2a;
    localparam logic [6:0] DL2_F72_LAST = 7'h38;
    localparam logic [6:0] DL3_F72_FIRST = 7'h3a;
    localparam logic [6:0] DL3_F72_LAST = 7'h48;
    localparam logic [6:0] DL1_F12_FIRST = 7'h02;
    localparam logic [6:0] DL1_F12_LAST = 7'h0c;
    typedef enum logic [1:0] {
        FMT_F4 = 2'b00,
        FMT_F12 = 2'b01,
        FMT_ESF = 2'b10,
        FMT_F72 = 2'b11
    } trpc_format_e;
endpackage

//--- tb/trpc_checker.sv
// Checker of register bus timing and read data of the receive performance counter block
`timescale 1ns/1ns
module trpc_checker
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Sequence monitor
    input wire logic seqSyncFlag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    rd_wait_a: assert property ($rose(avs_read) |-> one_wait)
        else $error("read not answered after one wait cycle");
    wr_wait_a: assert property ($rose(avs_write) |-> one_wait)
        else $error("write not answered after one wait cycle");
    idle_wait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest high without a request");
    rdata_upper_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    rdata_reset_a: assert property ($past(rst) |-> avs_readdata == 32'h00000000)
        else $error("read data not cleared by reset");
    rdata_hold_a: assert property (!$past(avs_read) && !$past(rst) |-> $stable(avs_readdata))
        else $error("read data changed without a read");
    unmapped_zero_a: assert property (rd_done ##0 (avs_address == 8'h40) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    align_hi_zero_a: assert property (rd_done ##0 (avs_address == trpc_pkg::REG_ALIGN_EVT_HI)
        |-> avs_readdata == 32'h0)
        else $error("event counter high byte read not zero");
    status_sync_a: assert property (rd_done ##0 (avs_address == trpc_pkg::REG_STATUS)
        |-> avs_readdata[0] == $past(seqSyncFlag))
        else $error("status read does not show sequence sync");
endmodule
bind trpc_perf_counters trpc_checker chk_i (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .seqSyncFlag(seqSyncFlag));

//--- tb/trpc_host_model.sv
// Host processor model issuing Avalon-MM register reads and writes
`timescale 1ns/1ns
module trpc_host_model
(
    // Clock
    input wire logic clk,
    // Avalon-MM master
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial
    begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
    end
    // Request held until waitrequest is sampled low, data taken at that edge
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wdata, output logic [7:0] rdata);
        @(posedge clk);
        avs_address <= idx;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, wdata};
        @(posedge clk);
        while (avs_waitrequest)
            @(posedge clk);
        rdata = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule

//--- tb/testbench.sv
// Self-checking testbench of the receive performance counter block
`timescale 1ns/1ns
module testbench;
    logic clk;
    logic rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // Pulses: begin, second, crc, framing, change, prbs, bit, dl strobe
    logic [7:0] ev;
    logic frameAlignLost;
    logic multiframeAlignLost;
    logic seqSyncFlag;
    logic dlBit;
    logic [6:0] dlFrameNum;
    logic [7:0] sigRegUpdated;
    logic [7:0] rdat;
    logic [7:0] prevDl1;
    int numErrors;
    int checked;
    trpc_host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    trpc_perf_counters dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxMultiframeBegin(ev[0]), .oneSecondTick(ev[1]),
        .crcErrorMf(ev[2]), .framingError(ev[3]), .frameAlignLost(frameAlignLost),
        .multiframeAlignLost(multiframeAlignLost), .alignChange(ev[4]), .prbsBitError(ev[5]),
        .seqSyncFlag(seqSyncFlag), .rxBitStrobe(ev[6]), .dlBitStrobe(ev[7]), .dlBit(dlBit),
        .dlFrameNum(dlFrameNum), .sigRegUpdated(sigRegUpdated));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic endSim();
        $display("comparisons %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        host.xfer(idx, 1'b0, 8'h00, d);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(idx, 1'b1, d, unused);
    endtask
    task automatic pulse(input int b, input int n);
        repeat (n)
        begin
            @(posedge clk);
            ev[b] <= 1'b1;
            @(posedge clk);
            ev[b] <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Optional freeze, then low byte before high byte
    task automatic getc(input string name, input logic [7:0] lo, input logic [7:0] frz, input logic [15:0] exp);
        logic [7:0] l;
        logic [7:0] h;
        if (frz != 8'h00)
            wr(trpc_pkg::REG_FREEZE, frz);
        rd(lo, l);
        rd(lo + 8'h01, h);
        chk(name, exp, {h, l});
    endtask
    function automatic logic g(input int f);
        return f[1] ^ f[3];
    endfunction
    task automatic dlRun(input logic [7:0] c, input int f1, input int f2, input int f3,
        input logic [7:0] m1, input logic [7:0] m2, input logic [7:0] m3);
        logic [7:0] e1;
        logic [7:0] e2;
        logic [7:0] e3;
        logic [7:0] d;
        wr(trpc_pkg::REG_CTRL, c);
        for (int f = 1; f <= 72; f++)
        begin
            @(posedge clk);
            dlFrameNum <= 7'(f);
            dlBit <= g(f);
            ev[7] <= 1'b1;
        end
        @(posedge clk);
        ev[7] <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            e1[i] = g(f1 + 2 * i);
            e2[i] = g(f2 + 2 * i);
            e3[i] = g(f3 + 2 * i);
        end
        rd(trpc_pkg::REG_DL1, d);
        chk("dl1 before begin", {8'h00, prevDl1 & m1}, {8'h00, d & m1});
        pulse(0, 1);
        rd(trpc_pkg::REG_DL1, d);
        chk("dl1", {8'h00, e1 & m1}, {8'h00, d & m1});
        rd(trpc_pkg::REG_DL2, d);
        chk("dl2", {8'h00, e2 & m2}, {8'h00, d & m2});
        rd(trpc_pkg::REG_DL3, d);
        chk("dl3", {8'h00, e3 & m3}, {8'h00, d & m3});
        prevDl1 = e1;
    endtask
    initial
    begin
        #(20000 * 4);
        numErrors++;
        endSim();
    end
    initial
    begin
        rst = 1'b1;
        ev = 8'h00;
        frameAlignLost = 1'b0;
        multiframeAlignLost = 1'b0;
        seqSyncFlag = 1'b0;
        dlBit = 1'b0;
        dlFrameNum = 7'h01;
        sigRegUpdated = 8'h00;
        prevDl1 = 8'h00;
        numErrors = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(trpc_pkg::REG_SIG_PTR1, rdat);
        chk("sig ptr reset", 16'h0000, {8'h00, rdat});
        rd(8'h40, rdat);
        chk("unmapped", 16'h0000, {8'h00, rdat});
        wr(trpc_pkg::REG_DL1, 8'hff);
        rd(trpc_pkg::REG_DL1, rdat);
        chk("dl1 read only", 16'h0000, {8'h00, rdat});
        wr(trpc_pkg::REG_CTRL, 8'h50);
        pulse(2, 3);
        wr(trpc_pkg::REG_FREEZE, 8'h01);
        pulse(2, 2);
        getc("crc frozen", trpc_pkg::REG_CRC_LO, 8'h00, 16'h0003);
        rd(trpc_pkg::REG_FREEZE, rdat);
        chk("freeze cleared", 16'h0000, {8'h00, rdat});
        getc("crc count", trpc_pkg::REG_CRC_LO, 8'h01, 16'h0002);
        frameAlignLost <= 1'b1;
        pulse(2, 2);
        getc("crc async", trpc_pkg::REG_CRC_LO, 8'h01, 16'h0000);
        frameAlignLost <= 1'b0;
        wr(trpc_pkg::REG_CTRL, 8'h40);
        pulse(2, 2);
        getc("crc disabled", trpc_pkg::REG_CRC_LO, 8'h01, 16'h0000);
        wr(trpc_pkg::REG_CTRL, 8'h50);
        pulse(0, 1);
        getc("block clear", trpc_pkg::REG_BLOCK_LO, 8'h02, 16'h0001);
        pulse(2, 1);
        pulse(3, 2);
        pulse(0, 1);
        pulse(3, 1);
        pulse(0, 1);
        getc("block esf", trpc_pkg::REG_BLOCK_LO, 8'h02, 16'h0002);
        getc("crc untouched", trpc_pkg::REG_CRC_LO, 8'h01, 16'h0001);
        wr(trpc_pkg::REG_CTRL, 8'h00);
        pulse(3, 2);
        pulse(0, 1);
        pulse(3, 1);
        pulse(0, 1);
        getc("block f4", trpc_pkg::REG_BLOCK_LO, 8'h02, 16'h0002);
        wr(trpc_pkg::REG_CTRL, 8'h58);
        pulse(0, 3);
        getc("crc sim", trpc_pkg::REG_CRC_LO, 8'h01, 16'h0003);
        getc("block sim esf", trpc_pkg::REG_BLOCK_LO, 8'h02, 16'h0003);
        getc("align sim", trpc_pkg::REG_ALIGN_EVT, 8'h08, 16'h0003);
        wr(trpc_pkg::REG_CTRL, 8'h00);
        wr(trpc_pkg::REG_CTRL, 8'h08);
        pulse(0, 5);
        getc("block sim f4", trpc_pkg::REG_BLOCK_LO, 8'h02, 16'h0001);
        pulse(6, 10);
        getc("biterr sim", trpc_pkg::REG_BITERR_LO, 8'h04, 16'h0005);
        wr(trpc_pkg::REG_CTRL, 8'h02);
        getc("align clear", trpc_pkg::REG_ALIGN_EVT, 8'h08, 16'h0003);
        seqSyncFlag <= 1'b1;
        pulse(5, 3);
        rd(trpc_pkg::REG_STATUS, rdat);
        chk("status sync", 16'h0001, {15'h0000, rdat[0]});
        seqSyncFlag <= 1'b0;
        pulse(5, 2);
        getc("biterr", trpc_pkg::REG_BITERR_LO, 8'h04, 16'h0003);
        wr(trpc_pkg::REG_CTRL, 8'h04);
        pulse(4, 5);
        multiframeAlignLost <= 1'b1;
        pulse(0, 3);
        multiframeAlignLost <= 1'b0;
        getc("align events", trpc_pkg::REG_ALIGN_EVT, 8'h08, 16'h000f);
        rd(trpc_pkg::REG_FREEZE, rdat);
        chk("align freeze cleared", 16'h0000, {8'h00, rdat});
        wr(trpc_pkg::REG_CTRL, 8'h51);
        pulse(2, 2);
        pulse(1, 1);
        pulse(2, 1);
        getc("crc latched", trpc_pkg::REG_CRC_LO, 8'h00, 16'h0002);
        pulse(1, 1);
        getc("crc relatched", trpc_pkg::REG_CRC_LO, 8'h00, 16'h0001);
        dlRun(8'h60, 26, 42, 58, 8'hff, 8'hff, 8'hff);
        dlRun(8'h40, 1, 17, 0, 8'hff, 8'h0f, 8'h00);
        dlRun(8'h20, 2, 0, 0, 8'h3f, 8'h00, 8'h00);
        @(posedge clk);
        sigRegUpdated <= 8'h05;
        @(posedge clk);
        sigRegUpdated <= 8'h80;
        @(posedge clk);
        sigRegUpdated <= 8'h00;
        rd(trpc_pkg::REG_SIG_PTR1, rdat);
        chk("sig ptr", 16'h0085, {8'h00, rdat});
        rd(trpc_pkg::REG_SIG_PTR1, rdat);
        chk("sig ptr after read", 16'h0000, {8'h00, rdat});
        endSim();
    end
endmodule
